// File: tb_wake_frame_filter.sv
// self-checking bench: avalon host and wake filter joined over the link
`timescale 1ns/10ps
`include "wff_defs.svh"
module tb_wake_frame_filter
  import wff_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic mac_valid = 1'b0;
  logic mac_sof = 1'b0;
  logic mac_eof = 1'b0;
  logic [7:0] mac_data = 8'h00;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wake_irq_level;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  wff_byte_t frm [0:19];
  logic [31:0] q;
  wff_byte_t rd;
  wff_if u_wff_if ();
  wff_host u_wff_host (.sys_clk(sys_clk), .rst_b(rst_b), .link(u_wff_if), .mac_valid(mac_valid),
    .mac_sof(mac_sof), .mac_eof(mac_eof), .mac_data(mac_data), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wake_irq_level(wake_irq_level));
  wff_dev u_wff_dev (.sys_clk(sys_clk), .rst_b(rst_b), .link(u_wff_if));
  wff_checker u_wff_checker (.sys_clk(sys_clk), .rst_b(rst_b), .rx_valid(u_wff_if.rx_valid),
    .rx_sof(u_wff_if.rx_sof), .rx_eof(u_wff_if.rx_eof), .reg_wr(u_wff_if.reg_wr),
    .reg_rd(u_wff_if.reg_rd), .reg_addr(u_wff_if.reg_addr), .reg_wdata(u_wff_if.reg_wdata),
    .reg_rvalid(u_wff_if.reg_rvalid), .wake_event(u_wff_if.wake_event),
    .wake_set(u_wff_if.wake_set), .phy_rst_n(u_wff_if.phy_rst_n));
  initial forever #10 sys_clk = ~sys_clk;
  // a hang anywhere ends here; real run is well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  function automatic wff_crc_t crc_acc(input wff_crc_t c, input wff_byte_t b);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ `WFF_CRC_POLY_R) : (c >> 1);
    return c;
  endfunction : crc_acc
  // returns {last selected byte, crc} over the current frame
  function automatic logic [23:0] pick(input int off, input logic [31:0] m);
    wff_crc_t c;
    wff_byte_t lb;
    c = `WFF_CRC_INIT;
    lb = 8'h00;
    for (int n = 0; n < 32; n++)
      if (m[n] && off * 2 + n < 20) begin
        c = crc_acc(c, frm[off * 2 + n]);
        lb = frm[off * 2 + n];
      end
    return {lb, c};
  endfunction : pick
  task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : av
  task automatic wait_idle();
    do
      av(`WFF_AV_CMD, 1'b0, 32'h0);
    while (q[`WFF_AV_BUSY_BIT] !== 1'b0);
    rd = q[7:0];
  endtask : wait_idle
  task automatic dev_wr(input wff_byte_t a, input wff_byte_t d);
    av(`WFF_AV_CMD, 1'b1, {15'h0, 1'b1, d, a});
    wait_idle();
  endtask : dev_wr
  task automatic dev_rd(input wff_byte_t a);
    av(`WFF_AV_CMD, 1'b1, {14'h0, 2'b10, 8'h00, a});
    wait_idle();
  endtask : dev_rd
  task automatic prog_set(input wff_byte_t ma, ca, oa, off, input logic [31:0] m,
      input wff_byte_t lb);
    logic [23:0] p;
    p = pick(off, m);
    for (int i = 0; i < 4; i++)
      dev_wr(wff_byte_t'(ma + i), m[8 * i +: 8]);
    dev_wr(ca, p[7:0]);
    dev_wr(wff_byte_t'(ca + 1), p[15:8]);
    dev_wr(oa, off);
    dev_wr(wff_byte_t'(oa + 2), lb);
  endtask : prog_set
  task automatic frame_check(input logic [1:0] exp);
    for (int i = 0; i < 20; i++) begin
      mac_valid <= 1'b1;
      mac_sof <= (i == 0);
      mac_eof <= (i == 19);
      mac_data <= frm[i];
      @(posedge sys_clk);
    end
    mac_valid <= 1'b0;
    mac_eof <= 1'b0;
    repeat (4) @(posedge sys_clk);
    av(`WFF_AV_WAKE, 1'b0, 32'h0);
    check(q[1:0], exp);
    check(wake_irq_level, |exp);
    av(`WFF_AV_WAKE, 1'b1, 32'h103);
  endtask : frame_check
  // ==========================================================
  // scenarios
  task automatic t_reset();
    dev_rd(`WFF_OFF1);
    check(rd, 8'h00);
    dev_rd(`WFF_LB1);
    check(rd, 8'h00);
    av(`WFF_AV_PHY, 1'b0, 32'h0);
    check(q[0], 1'b1);
  endtask : t_reset
  task automatic t_phy();
    dev_wr(`WFF_PHY_CTL, 8'h03);
    av(`WFF_AV_PHY, 1'b0, 32'h0);
    check(q[0], 1'b0);
    check(u_wff_if.phy_rst_n, 1'b0);
    dev_rd(`WFF_PHY_CTL);
    check(rd[2:0], 3'h3);
    dev_wr(`WFF_PHY_CTL, 8'h07);
    av(`WFF_AV_PHY, 1'b0, 32'h0);
    check(q[0], 1'b1);
  endtask : t_phy
  task automatic t_set0();
    frm = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'h01, 8'h02, 8'h03, 8'h04,
      8'h05, 8'h06, 8'h08, 8'h00, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
    prog_set(`WFF_MASK0, `WFF_CRC0, `WFF_OFF0, 8'h00, 32'h0000_303F, 8'h00);
    dev_rd(wff_byte_t'(`WFF_MASK0 + 1));
    check(rd, 8'h30);
    av(`WFF_AV_WAKE, 1'b1, 32'h100);
    dev_wr(`WFF_CTL, 8'h01);
    frame_check(2'b01);
    av(`WFF_AV_WAKE, 1'b0, 32'h0);
    check(q[1:0], 2'b00);
    check(q[8], 1'b1);
    dev_rd(`WFF_STAT);
    check(rd, 8'h01);
    dev_wr(`WFF_STAT, 8'h01);
    dev_rd(`WFF_STAT);
    check(rd, 8'h00);
    frm[12] = 8'h09;
    frame_check(2'b00);
    frm[12] = 8'h08;
  endtask : t_set0
  task automatic t_set1();
    // wrong last byte: first selected byte instead of the last
    prog_set(`WFF_MASK1, `WFF_CRC1, `WFF_OFF1, 8'h01, 32'h0000_0005, 8'h56);
    dev_wr(`WFF_CTL, 8'h02);
    frame_check(2'b00);
    dev_wr(`WFF_LB1, 8'h9A);
    frame_check(2'b10);
    dev_wr(`WFF_CTL, 8'h03);
    frame_check(2'b11);
    dev_wr(`WFF_CTL, 8'h00);
    frame_check(2'b00);
  endtask : t_set1
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_phy();
    t_set0();
    t_set1();
    finish_test();
  end
endmodule : tb_wake_frame_filter

// File: wff_checker.sv
// concurrent checks on the link between the wake filter ends
`timescale 1ns/10ps
`include "wff_defs.svh"
module wff_checker
  import wff_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire wff_byte_t reg_addr,
  input wire wff_byte_t reg_wdata,
  input wire logic reg_rvalid,
  input wire logic wake_event,
  input wire logic [1:0] wake_set,
  input wire logic phy_rst_n
);
  // ==========================================================
  // helper: enables as last written
  logic [1:0] en_q;
  wire ctl_wr = reg_wr && reg_addr == `WFF_CTL;
  wire phy_wr = reg_wr && reg_addr == `WFF_PHY_CTL;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      en_q <= 2'b00;
    else if (ctl_wr)
      en_q <= reg_wdata[1:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // properties
  property p_phy_follow;
    phy_wr |-> ##2 phy_rst_n == $past(reg_wdata[2], 2);
  endproperty
  a_phy_follow: assert property (p_phy_follow) else $error("phy reset lags control");
  property p_phy_cause;
    $changed(phy_rst_n) |-> $past(phy_wr, 2);
  endproperty
  a_phy_cause: assert property (p_phy_cause) else $error("phy reset moved alone");
  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rvalid_cause;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read answer");
  property p_wake_after_eof;
    wake_event |-> $past(rx_valid && rx_eof);
  endproperty
  a_wake_after_eof: assert property (p_wake_after_eof) else $error("wake not after end");
  property p_wake_nonzero;
    wake_event |-> wake_set != 2'b00;
  endproperty
  a_wake_nonzero: assert property (p_wake_nonzero) else $error("wake with no set");
  property p_wake_enabled;
    wake_event |-> (wake_set & ~en_q) == 2'b00;
  endproperty
  a_wake_enabled: assert property (p_wake_enabled) else $error("disabled set matched");
  property p_no_wake_midframe;
    rx_valid && rx_sof && !rx_eof |=> !wake_event;
  endproperty
  a_no_wake_midframe: assert property (p_no_wake_midframe) else $error("wake mid frame");
  c_wake0: cover property (wake_event && wake_set[0]);
  c_wake1: cover property (wake_event && wake_set[1]);
  c_phy_held: cover property (!phy_rst_n);
endmodule : wff_checker

// File: wff_defs.svh
// offsets, field positions, reset values and constants of the wake frame filter
`ifndef WFF_DEFS_SVH
`define WFF_DEFS_SVH

// ==========================================================
// device register map (byte addresses on the device port)
`define WFF_PHY_CTL 8'h22
`define WFF_MASK0 8'h32
`define WFF_CRC0 8'h36
`define WFF_OFF0 8'h38
`define WFF_LB0 8'h3A
`define WFF_MASK1 8'h40
`define WFF_CRC1 8'h44
`define WFF_OFF1 8'h46
`define WFF_LB1 8'h48
`define WFF_CTL 8'h4A
`define WFF_STAT 8'h4B

// ==========================================================
// fields and reset values
`define WFF_PHY_CTL_RST 8'h07
`define WFF_PHY_RUN_BIT 2
`define WFF_MASK_RST 32'h0000_0000
`define WFF_CRC_RST 16'h0000
`define WFF_BYTE_RST 8'h00
`define WFF_CRC_INIT 16'h0000
`define WFF_CRC_POLY_R 16'hA001
`define WFF_MASK_BITS 32

// ==========================================================
// controller registers on the avalon side (byte addresses)
`define WFF_AV_CMD 4'h0
`define WFF_AV_WAKE 4'h4
`define WFF_AV_PHY 4'h8
`define WFF_AV_CMD_WR_BIT 16
`define WFF_AV_CMD_RD_BIT 17
`define WFF_AV_BUSY_BIT 8
`define WFF_AV_WAKE_EN_BIT 8

`endif

// File: wff_dev.sv
// wake frame filter: two pattern sets checked over each received frame
// Operation
// - crc starts at byte twice the offset
// - last-byte pattern compared to last masked byte
// - last masked byte is highest set mask bit
// - wake only when crc and last byte match
// - mask bit n selects byte n after offset
// - software enables set last via control register
// - software enables the wake frame event
// - crc covers masked bytes only, in order
// - phy held in reset while control bit 2 low
// - software writes 11 into phy bits 1:0
// - crc16 poly x16+x15+x2+1 compared per set
// - 32 bit byte mask, low byte bits 7:0
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`include "wff_defs.svh"
module wff_dev
  import wff_pkg::*;
#(
  parameter int SETS = 2,
  parameter int CNT_W = 11
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  wff_if.dev link
);

  // ==========================================================
  // helpers
  // reflected form of x^16+x^15+x^2+1, bits of each byte taken lsb first
  function automatic wff_crc_t crc_byte(input wff_crc_t c, input wff_byte_t d);
    wff_crc_t r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      r = {1'b0, r[15:1]};
      if (fb) r = r ^ `WFF_CRC_POLY_R;
    end
    return r;
  endfunction : crc_byte

  function automatic logic hit(input wff_byte_t a, input wff_byte_t base);
    return a == base;
  endfunction : hit

  // ==========================================================
  // registers
  logic [31:0] mask_q [SETS];
  wff_crc_t ref_q [SETS];
  wff_byte_t off_q [SETS];
  wff_byte_t lb_q [SETS];
  wff_byte_t ctl_q;
  wff_byte_t phy_ctl_q;
  logic [1:0] stat_q;
  wff_byte_t rdata_q;
  logic rvalid_q;
  logic wake_q;
  logic [1:0] wake_set_q;
  logic phy_run_q;

  wire wr_w = link.reg_wr;
  wire [7:0] a_w = link.reg_addr;
  wire [7:0] wd_w = link.reg_wdata;

  // ==========================================================
  // frame byte position
  logic [CNT_W-1:0] cnt_q;
  wire byte_w = link.rx_valid;
  wire sof_w = link.rx_valid & link.rx_sof;
  wire eof_w = link.rx_valid & link.rx_eof;
  wire [CNT_W-1:0] idx_w = sof_w ? '0 : cnt_q;
  wire cnt_max_w = &cnt_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= '0;
    else if (byte_w && !(cnt_max_w && !sof_w)) cnt_q <= idx_w + 1'b1;
  end

  // ==========================================================
  // per set pattern registers and matcher
  logic [SETS-1:0] match_w;
  wff_byte_t rd_set_w [SETS];
  logic [SETS-1:0] rd_hit_w;

  genvar s;
  generate
    for (s = 0; s < SETS; s++) begin : g_set
      wire [7:0] mb_w = (s == 0) ? `WFF_MASK0 : `WFF_MASK1;
      wire [7:0] cb_w = (s == 0) ? `WFF_CRC0 : `WFF_CRC1;
      wire [7:0] ob_w = (s == 0) ? `WFF_OFF0 : `WFF_OFF1;
      wire [7:0] lb_w = (s == 0) ? `WFF_LB0 : `WFF_LB1;
      wire [1:0] mk_sel_w = 2'(a_w - mb_w);
      wire in_mask_w = (a_w >= mb_w) && (a_w < 8'(mb_w + 8'h04));
      wire crc_hi_w = hit(a_w, 8'(cb_w + 8'h01));

      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          mask_q[s] <= `WFF_MASK_RST;
          ref_q[s] <= `WFF_CRC_RST;
          off_q[s] <= `WFF_BYTE_RST;
          lb_q[s] <= `WFF_BYTE_RST;
        end else if (wr_w) begin
          // mask byte k holds mask bits 8k+7..8k
          if (in_mask_w) mask_q[s][8*mk_sel_w +: 8] <= wd_w;
          if (hit(a_w, cb_w)) ref_q[s][7:0] <= wd_w;
          if (crc_hi_w) ref_q[s][15:8] <= wd_w;
          if (hit(a_w, ob_w)) off_q[s] <= wd_w;
          if (hit(a_w, lb_w)) lb_q[s] <= wd_w;
        end
      end

      assign rd_hit_w[s] = in_mask_w | hit(a_w, cb_w) | crc_hi_w | hit(a_w, ob_w) |
                           hit(a_w, lb_w);
      assign rd_set_w[s] = in_mask_w ? mask_q[s][8*mk_sel_w +: 8] :
                           hit(a_w, cb_w) ? ref_q[s][7:0] :
                           crc_hi_w ? ref_q[s][15:8] :
                           hit(a_w, ob_w) ? off_q[s] : lb_q[s];

      // window of 32 bytes starting at twice the offset
      wire [CNT_W-1:0] start_w = CNT_W'({off_q[s], 1'b0});
      wire [CNT_W-1:0] rel_w = idx_w - start_w;
      wire in_win_w = (idx_w >= start_w) && (rel_w < CNT_W'(`WFF_MASK_BITS));
      wire sel_w = byte_w && in_win_w && mask_q[s][rel_w[4:0]];

      wff_crc_t crc_q;
      wff_byte_t last_q;
      logic seen_q;
      wire wff_crc_t base_crc_w = sof_w ? `WFF_CRC_INIT : crc_q;
      // only selected bytes feed the crc, in frame order
      wire wff_crc_t crc_d_w = sel_w ? crc_byte(base_crc_w, link.rx_data) : base_crc_w;
      // later selected bytes overwrite, so the highest mask bit seen is kept
      wire wff_byte_t last_d_w = sel_w ? link.rx_data : (sof_w ? `WFF_BYTE_RST : last_q);
      wire seen_d_w = sel_w | (seen_q & !sof_w);
      wire crc_ok_w = (crc_d_w == ref_q[s]);
      wire lb_ok_w = (last_d_w == lb_q[s]);

      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          crc_q <= `WFF_CRC_INIT;
          last_q <= `WFF_BYTE_RST;
          seen_q <= 1'b0;
        end else if (byte_w) begin
          crc_q <= crc_d_w;
          last_q <= last_d_w;
          seen_q <= seen_d_w;
        end
      end

      assign match_w[s] = eof_w && ctl_q[s] && seen_d_w && crc_ok_w && lb_ok_w;
    end
  endgenerate

  // ==========================================================
  // control, phy and status registers
  wire hit_phy_w = hit(a_w, `WFF_PHY_CTL);
  wire hit_ctl_w = hit(a_w, `WFF_CTL);
  wire hit_stat_w = hit(a_w, `WFF_STAT);
  wire [1:0] stat_clr_w = {2{wr_w & hit_stat_w}} & wd_w[1:0];

  // sets are enabled here, so software writes this after the pattern
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= `WFF_BYTE_RST;
      phy_ctl_q <= `WFF_PHY_CTL_RST;
    end else if (wr_w) begin
      if (hit_ctl_w) ctl_q <= wd_w;
      // bits 1:0 are stored as written; software keeps them at 11
      if (hit_phy_w) phy_ctl_q <= wd_w;
    end
  end

  // a match in the clearing cycle survives
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) stat_q <= 2'b00;
    else stat_q <= (stat_q & ~stat_clr_w) | match_w;
  end

  // ==========================================================
  // register read port, answer one cycle after the strobe
  wire rd_set0_w = rd_hit_w[0];
  wire rd_set1_w = rd_hit_w[1];
  wire wff_byte_t rd_mux_w = hit_phy_w ? phy_ctl_q :
                             hit_ctl_w ? ctl_q :
                             hit_stat_w ? {6'h00, stat_q} :
                             rd_set0_w ? rd_set_w[0] :
                             rd_set1_w ? rd_set_w[1] : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= `WFF_BYTE_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= link.reg_rd;
      if (link.reg_rd) rdata_q <= rd_mux_w;
    end
  end

  // ==========================================================
  // outputs
  // the event enable lives with the wake logic outside; this only flags
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_q <= 1'b0;
      wake_set_q <= 2'b00;
      phy_run_q <= 1'b1;
    end else begin
      wake_q <= |match_w;
      wake_set_q <= match_w;
      phy_run_q <= phy_ctl_q[`WFF_PHY_RUN_BIT];
    end
  end

  assign link.reg_rdata = rdata_q;
  assign link.reg_rvalid = rvalid_q;
  assign link.wake_event = wake_q;
  assign link.wake_set = wake_set_q;
  assign link.phy_rst_n = phy_run_q;

endmodule : wff_dev

// File: wff_host.sv
// receive path controller: forwards frames and drives filter registers from avalon
`timescale 1ns/10ps
`include "wff_defs.svh"
module wff_host
  import wff_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  wff_if.host link,
  input wire logic mac_valid,
  input wire logic mac_sof,
  input wire logic mac_eof,
  input wire logic [7:0] mac_data,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic wake_irq_level
);

  // ==========================================================
  // frame forwarding, one cycle of latency
  logic rx_valid_q, rx_sof_q, rx_eof_q;
  wff_byte_t rx_data_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid_q <= 1'b0;
      rx_sof_q <= 1'b0;
      rx_eof_q <= 1'b0;
      rx_data_q <= `WFF_BYTE_RST;
    end else begin
      rx_valid_q <= mac_valid;
      rx_sof_q <= mac_valid & mac_sof;
      rx_eof_q <= mac_valid & mac_eof;
      rx_data_q <= mac_data;
    end
  end
  assign link.rx_valid = rx_valid_q;
  assign link.rx_sof = rx_sof_q;
  assign link.rx_eof = rx_eof_q;
  assign link.rx_data = rx_data_q;

  // ==========================================================
  // avalon slave
  wire req_w = (avs_read | avs_write) & avs_waitrequest;
  wire wr_cmd_w = avs_write & avs_waitrequest & (avs_address == `WFF_AV_CMD);
  wire wr_wake_w = avs_write & avs_waitrequest & (avs_address == `WFF_AV_WAKE);
  wire go_w = wr_cmd_w & (avs_writedata[`WFF_AV_CMD_WR_BIT] | avs_writedata[`WFF_AV_CMD_RD_BIT]);

  wff_host_state_t state_q, state_d;
  logic reg_wr_q, reg_rd_q;
  wff_byte_t addr_q, wdata_q, rdata_q;
  logic [1:0] wake_q;
  logic wait_q;
  logic [31:0] avs_rdata_q;
  logic ev_en_q;
  logic wake_q_any_q;
  wire busy_w = (state_q != WFF_IDLE);

  // orders arriving while busy are dropped; software polls busy first
  always_comb begin
    state_d = state_q;
    case (state_q)
      WFF_IDLE: begin
        if (go_w && avs_writedata[`WFF_AV_CMD_RD_BIT]) state_d = WFF_RD_WAIT;
        else if (go_w) state_d = WFF_DONE;
      end
      WFF_RD_WAIT: if (link.reg_rvalid) state_d = WFF_IDLE;
      WFF_DONE: state_d = WFF_IDLE;
      default: state_d = WFF_IDLE;
    endcase
  end

  wire [31:0] rd_mux_w = (avs_address == `WFF_AV_CMD) ?
                         {23'h0, busy_w, rdata_q} :
                         (avs_address == `WFF_AV_WAKE) ? {23'h0, ev_en_q, 6'h00, wake_q} :
                         (avs_address == `WFF_AV_PHY) ? {31'h0, link.phy_rst_n} : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= WFF_IDLE;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      addr_q <= `WFF_BYTE_RST;
      wdata_q <= `WFF_BYTE_RST;
      rdata_q <= `WFF_BYTE_RST;
      wake_q <= 2'b00;
      ev_en_q <= 1'b0;
      wait_q <= 1'b1;
      avs_rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      reg_wr_q <= go_w & !busy_w & !avs_writedata[`WFF_AV_CMD_RD_BIT];
      reg_rd_q <= go_w & !busy_w & avs_writedata[`WFF_AV_CMD_RD_BIT];
      if (go_w && !busy_w) begin
        addr_q <= avs_writedata[7:0];
        wdata_q <= avs_writedata[15:8];
      end
      if (link.reg_rvalid) rdata_q <= link.reg_rdata;
      // a new match wins over a clear in the same cycle
      wake_q <= (wake_q & ~({2{wr_wake_w}} & avs_writedata[1:0])) |
                ({2{link.wake_event}} & link.wake_set);
      wait_q <= !(req_w);
      if (wr_wake_w) ev_en_q <= avs_writedata[`WFF_AV_WAKE_EN_BIT];
      if (avs_read && avs_waitrequest) avs_rdata_q <= rd_mux_w;
    end
  end
  assign link.reg_wr = reg_wr_q;
  assign link.reg_rd = reg_rd_q;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = wdata_q;
  assign avs_waitrequest = wait_q;
  assign avs_readdata = avs_rdata_q;
  assign wake_irq_level = wake_q_any_q;

  // matches still latch while the event enable is off; only the level is gated
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) wake_q_any_q <= 1'b0;
    else wake_q_any_q <= ev_en_q & (|wake_q);
  end

endmodule : wff_host

// File: wff_if.sv
// link between the receive path controller and the wake frame filter
`timescale 1ns/10ps
interface wff_if;
  import wff_pkg::*;
  logic rx_valid;
  logic rx_sof;
  logic rx_eof;
  wff_byte_t rx_data;
  logic reg_wr;
  logic reg_rd;
  wff_byte_t reg_addr;
  wff_byte_t reg_wdata;
  wff_byte_t reg_rdata;
  logic reg_rvalid;
  logic wake_event;
  logic [1:0] wake_set;
  logic phy_rst_n;

  modport dev (
    input rx_valid, rx_sof, rx_eof, rx_data, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid, wake_event, wake_set, phy_rst_n
  );
  modport host (
    output rx_valid, rx_sof, rx_eof, rx_data, reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_rvalid, wake_event, wake_set, phy_rst_n
  );
endinterface : wff_if

// File: wff_pkg.sv
// types shared by both ends of the wake frame filter
package wff_pkg;
  typedef logic [7:0] wff_byte_t;
  typedef logic [15:0] wff_crc_t;
  typedef enum logic [1:0] {
    WFF_IDLE = 2'b00,
    WFF_RD_WAIT = 2'b01,
    WFF_DONE = 2'b10
  } wff_host_state_t;
endpackage : wff_pkg
